/* File: core/tcg_regs.vh */
// Constants for the thermistor charge guard: register indices, field positions, reset values and timing.
// Assumes a 50 MHz system clock and an 8-bit register port driven by an external serial slave engine.
`ifndef TCG_REGS_VH
`define TCG_REGS_VH

// Clock rate in kHz, sampling timing in microseconds, interrupt pulse and clock period in nanoseconds.
`define TCG_CLK_KHZ          50000
`define TCG_BIAS_WIN_US      25000
`define TCG_BIAS_PERIOD_US   225000
`define TCG_INT_PULSE_NS     128000
`define TCG_CLK_NS           20

// Register indices on the byte-wide register port.
`define TCG_IDX_COLD         8'h00
`define TCG_IDX_COOL         8'h01
`define TCG_IDX_WARM         8'h02
`define TCG_IDX_HOT          8'h03
`define TCG_IDX_ADJUST       8'h04
`define TCG_IDX_CONFIG       8'h05
`define TCG_IDX_FAULT        8'h06
`define TCG_IDX_SENSE        8'h07
`define TCG_IDX_AUX          8'h08
`define TCG_IDX_OPEN         8'h09

// Default threshold codes: 256 * V / 1.2 V, 8 MSBs of the conversion.
`define TCG_RST_COLD         8'h7C
`define TCG_RST_COOL         8'h6D
`define TCG_RST_WARM         8'h38
`define TCG_RST_HOT          8'h27
`define TCG_RST_OPEN         8'hC0
`define TCG_RST_ADJUST       8'h00
`define TCG_RST_CONFIG       8'h00
`define TCG_UNMAPPED         8'hFF

// Profile encoding in config bits 1:0.
`define TCG_PROF_FULL        2'h0
`define TCG_PROF_HOTCOLD     2'h1
`define TCG_PROF_OFF         2'h2

// Config bit positions.
`define TCG_CFG_PROF_LSB     0
`define TCG_CFG_BIAS_OFF     2
`define TCG_CFG_AUX_NTC      3

// Adjust register fields: fraction bits 2:0, voltage code bits 7:4.
`define TCG_ADJ_FRAC_LSB     0
`define TCG_ADJ_VREG_LSB     4

// Fault register bits.
`define TCG_FLT_HOT          0
`define TCG_FLT_WARM         1
`define TCG_FLT_COOL         2
`define TCG_FLT_COLD         3
`define TCG_FLT_OPEN         4

// Region one-hot bit positions.
`define TCG_RG_NORMAL        0
`define TCG_RG_HOT           1
`define TCG_RG_WARM          2
`define TCG_RG_COOL          3
`define TCG_RG_COLD          4
`define TCG_RG_OPEN          5

`endif

/* File: core/tcg_sample_timer.v */
// Sampling window timer for the thermistor charge guard.
// Assumes one clock and a synchronous active-high reset; the enable comes from same-clock logic.
`include "tcg_regs.vh"

module tcg_sample_timer #(
  parameter integer WIN_CYC    = 1250000,
  parameter integer PERIOD_CYC = 11250000
) (
  input  wire        sys_clk_in,
  input  wire        sys_rst_in,
  input  wire        run_in,
  output reg         bias_out,
  output reg         done_out
);

  localparam [31:0] LAST_CYC = PERIOD_CYC - 1;

  reg  [31:0] count_reg;

  // Free-running period counter; bias is on during the first part of each period.
  // Parking on the last count makes the first window after a start as long as every later one.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in || !run_in) begin
      count_reg <= LAST_CYC;
      bias_out  <= 1'b0;
      done_out  <= 1'b0;
    end else begin
      if (count_reg == LAST_CYC)
        count_reg <= 32'h0000_0000;
      else
        count_reg <= count_reg + 32'h0000_0001;
      bias_out <= (count_reg < WIN_CYC - 1) || (count_reg == LAST_CYC);
      done_out <= (count_reg == WIN_CYC - 1); // End of window: sample is complete.
    end
  end

endmodule

/* File: core/tcg_guard.v */
// Thermistor charge guard: sampling control, region classification, charge actions and fault reporting.
// Assumes an external serial slave presents byte register accesses as one-cycle strobes on this clock,
// and an external converter delivers results in the sense domain, synchronised here.
`include "tcg_regs.vh"

// Register map on the byte-wide port, by index:
//   00 cold limit code, 01 cool limit code.
//   02 warm limit code, 03 hot limit code.
//   04 charge adjust: bits 2:0 fraction code f.
//      Bits 7:4 hold the reduced regulation voltage code.
//   05 config: bits 1:0 profile, 0 full, 1 hot/cold, 2 off.
//      Bit 2 stops sampling, but only on battery alone.
//      Bit 3 puts the aux input in thermistor mode.
//   06 fault bits, cleared by the read that returns them.
//      Bit 0 hot, 1 warm, 2 cool, 3 cold, 4 open sensor.
//   07 last sense code, 08 last aux code.
//   09 open-sensor limit code.
// Writes to 06, 07, 08 or unmapped indices are dropped.
// Unmapped reads return all ones.
//
// Timing of one sample, in clock cycles:
//   The timer raises bias for WIN_CYC cycles each period.
//   The bias pin follows one cycle later through its flop.
//   The converter result crosses two flops on its way in.
//   At the window end the top byte is judged once.
//   The region changes on that edge, the pulse starts with it.
//   Charge outputs follow the region one cycle later.
//
// Limitations a user must know:
//   A swing that starts and ends between windows is not seen.
//   This trades response time for a low average bias current.
//   Leaving a fault region for normal sets no fault bit.
//   The host can still follow recovery through the sense code.
//   A fault during a running pulse restarts that pulse.
//   Two close faults therefore merge into one longer pulse.
//   The fraction code f gives (8 - f) eighths of the setting.
//   Results between current steps fall to the lower step.
//   The open limit is judged in every profile, off too.
//   That keeps charging off with a missing sensor.

// Operation
// - With supply valid, bias the sense pin 25 ms every 225 ms only.
// - Software bias-off request ignored while the input supply is present.
// - Profiles: full four-threshold, hot/cold only, or temperature control off.
// - Beyond hot or cold limit, suspend charging and safety timer.
// - Between cool and cold, reduce fast-charge current by the selected fraction.
// - Reduced current truncated down to whole fast-charge current steps.
// - Between hot and warm, lower regulation voltage to the selected value.
// - Every temperature fault gives one 128 us interrupt pulse, any profile.
// - Fault bits latch until host read, the read clearing them.
// - Crossing any of hot, warm, cool or cold thresholds raises an interrupt; the code pulses only on entry to a fault region, not on return to normal.
// - Reading above open-sensor limit disables charging as missing sensor.
// - Converter full scale is 1.2 V.
// - Threshold registers compare with the eight MSBs of the conversion.
// - Default thresholds are 0.585, 0.514, 0.265 and 0.185 V codes.
// - Sense voltage readable whenever input supply or battery present.
// - Auxiliary input in thermistor mode is biased and sampled the same way.
module tcg_guard #(
  parameter integer WIN_CYC      = (`TCG_BIAS_WIN_US * (`TCG_CLK_KHZ / 1000)),
  parameter integer PERIOD_CYC   = (`TCG_BIAS_PERIOD_US * (`TCG_CLK_KHZ / 1000)),
  parameter integer ADC_W        = 16,
  parameter integer FAST_CHARGE_CURRENT_SETTING_W       = 9
) (
  input  wire              sys_clk_in,
  input  wire              sys_rst_in,
  input  wire              supply_valid_in,
  input  wire              battery_present_in,
  input  wire [ADC_W-1:0]  sense_code_in,
  input  wire [ADC_W-1:0]  aux_code_in,
  input  wire [FAST_CHARGE_CURRENT_SETTING_W-1:0] fast_charge_current_setting_in,
  input  wire              reg_wr_in,
  input  wire              reg_rd_in,
  input  wire [7:0]        reg_addr_in,
  input  wire [7:0]        reg_wdata_in,
  output reg  [7:0]        reg_rdata_out,
  output reg               sense_bias_out,
  output reg               aux_bias_out,
  output reg               charge_enable_out,
  output reg               safety_timer_hold_out,
  output reg  [FAST_CHARGE_CURRENT_SETTING_W-1:0] charge_current_out,
  output reg               vreg_reduce_out,
  output reg  [3:0]        vreg_code_out,
  output reg               int_pulse_out
);

  localparam integer PULSE_CYC = (`TCG_INT_PULSE_NS / `TCG_CLK_NS);

  // Region one-hot states.
  localparam [5:0] RG_NORMAL = 6'h01;
  localparam [5:0] RG_HOT    = 6'h02;
  localparam [5:0] RG_WARM   = 6'h04;
  localparam [5:0] RG_COOL   = 6'h08;
  localparam [5:0] RG_COLD   = 6'h10;
  localparam [5:0] RG_OPEN   = 6'h20;

  // Registers.
  reg  [7:0]        cold_limit_code_reg;
  reg  [7:0]        cool_limit_code_reg;
  reg  [7:0]        warm_limit_code_reg;
  reg  [7:0]        hot_limit_code_reg;
  reg  [7:0]        open_limit_code_reg;
  reg  [7:0]        temp_charge_adjust_reg;
  reg  [7:0]        config_reg;
  reg  [4:0]        fault_reg;
  reg  [7:0]        sense_hold_reg;
  reg  [7:0]        aux_hold_reg;
  reg  [5:0]        region_reg;
  reg  [5:0]        region_next;
  reg  [12:0]       pulse_cnt_reg;
  reg  [ADC_W-1:0]  sense_s1_reg;
  reg  [ADC_W-1:0]  sense_s2_reg;
  reg  [ADC_W-1:0]  aux_s1_reg;
  reg  [ADC_W-1:0]  aux_s2_reg;
  reg               supply_s1_reg;
  reg               supply_s2_reg;
  reg               batt_s1_reg;
  reg               batt_s2_reg;
  reg  [4:0]        fault_set;
  reg  [7:0]        rdata_next;
  reg  [FAST_CHARGE_CURRENT_SETTING_W+2:0] scaled_current;

  wire              timer_run;
  wire              timer_bias;
  wire              timer_done;
  wire [1:0]        profile;
  wire [7:0]        sample_code;

  // Classifies one 8-bit code into a region under the given profile.
  function [5:0] classify;
    input [7:0] code;
    input [1:0] prof;
    input [7:0] c_cold;
    input [7:0] c_cool;
    input [7:0] c_warm;
    input [7:0] c_hot;
    input [7:0] c_open;
    begin
      if (code > c_open)
        classify = RG_OPEN;
      else if (prof == `TCG_PROF_OFF)
        classify = RG_NORMAL;
      else if (code > c_cold)
        classify = RG_COLD;
      else if (code < c_hot)
        classify = RG_HOT;
      else if (prof == `TCG_PROF_HOTCOLD)
        classify = RG_NORMAL;
      else if (code > c_cool)
        classify = RG_COOL;
      else if (code < c_warm)
        classify = RG_WARM;
      else
        classify = RG_NORMAL;
    end
  endfunction

  // Pin inputs from the converter and supply monitors cross two flops first.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sense_s1_reg  <= {ADC_W{1'b0}};
      sense_s2_reg  <= {ADC_W{1'b0}};
      aux_s1_reg    <= {ADC_W{1'b0}};
      aux_s2_reg    <= {ADC_W{1'b0}};
      supply_s1_reg <= 1'b0;
      supply_s2_reg <= 1'b0;
      batt_s1_reg   <= 1'b0;
      batt_s2_reg   <= 1'b0;
    end else begin
      sense_s1_reg  <= sense_code_in;
      sense_s2_reg  <= sense_s1_reg;
      aux_s1_reg    <= aux_code_in;
      aux_s2_reg    <= aux_s1_reg;
      supply_s1_reg <= supply_valid_in;
      supply_s2_reg <= supply_s1_reg;
      batt_s1_reg   <= battery_present_in;
      batt_s2_reg   <= batt_s1_reg;
    end
  end

  assign profile = config_reg[`TCG_CFG_PROF_LSB +: 2];

  // The bias-off bit only counts on battery alone; with supply present sampling is forced.
  assign timer_run = supply_s2_reg || (batt_s2_reg && !config_reg[`TCG_CFG_BIAS_OFF]);

  // The 16-bit result maps 1.2 V to full scale; its top byte meets the thresholds.
  assign sample_code = sense_s2_reg[ADC_W-1 -: 8];

  tcg_sample_timer #(
    .WIN_CYC    (WIN_CYC),
    .PERIOD_CYC (PERIOD_CYC)
  ) u_timer (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .run_in     (timer_run),
    .bias_out   (timer_bias),
    .done_out   (timer_done)
  );

  // Region updates only from a completed window, so actions hold between samples.
  always @* begin
    region_next = region_reg;
    if (timer_done)
      region_next = classify(sample_code, profile, cold_limit_code_reg, cool_limit_code_reg,
                             warm_limit_code_reg, hot_limit_code_reg, open_limit_code_reg);
  end

  // A fault is set on entry to any region but normal; leaving normal through any threshold is a crossing.
  always @* begin
    fault_set = 5'h00;
    if (region_next != region_reg) begin
      fault_set[`TCG_FLT_HOT]  = region_next[`TCG_RG_HOT];
      fault_set[`TCG_FLT_WARM] = region_next[`TCG_RG_WARM];
      fault_set[`TCG_FLT_COOL] = region_next[`TCG_RG_COOL];
      fault_set[`TCG_FLT_COLD] = region_next[`TCG_RG_COLD];
      fault_set[`TCG_FLT_OPEN] = region_next[`TCG_RG_OPEN];
    end
  end

  // Scaled current: fraction code f gives (8-f)/8 of the setting, integer divide truncates down.
  always @* begin
    scaled_current = {3'b000, fast_charge_current_setting_in} *
                     ({{FAST_CHARGE_CURRENT_SETTING_W{1'b0}}, 3'h0} + {{FAST_CHARGE_CURRENT_SETTING_W{1'b0}}, 3'h7} -
                      {{FAST_CHARGE_CURRENT_SETTING_W{1'b0}}, temp_charge_adjust_reg[`TCG_ADJ_FRAC_LSB +: 3]} + 1'b1);
  end

  // Register writes; thresholds default to the 10k sensor codes.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cold_limit_code_reg    <= `TCG_RST_COLD;
      cool_limit_code_reg    <= `TCG_RST_COOL;
      warm_limit_code_reg    <= `TCG_RST_WARM;
      hot_limit_code_reg     <= `TCG_RST_HOT;
      open_limit_code_reg    <= `TCG_RST_OPEN;
      temp_charge_adjust_reg <= `TCG_RST_ADJUST;
      config_reg             <= `TCG_RST_CONFIG;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `TCG_IDX_COLD:   cold_limit_code_reg    <= reg_wdata_in;
        `TCG_IDX_COOL:   cool_limit_code_reg    <= reg_wdata_in;
        `TCG_IDX_WARM:   warm_limit_code_reg    <= reg_wdata_in;
        `TCG_IDX_HOT:    hot_limit_code_reg     <= reg_wdata_in;
        `TCG_IDX_OPEN:   open_limit_code_reg    <= reg_wdata_in;
        `TCG_IDX_ADJUST: temp_charge_adjust_reg <= reg_wdata_in;
        `TCG_IDX_CONFIG: config_reg             <= reg_wdata_in;
        default:         config_reg             <= config_reg;
      endcase
    end
  end

  // Read mux; unmapped indices return all ones.
  always @* begin
    case (reg_addr_in)
      `TCG_IDX_COLD:   rdata_next = cold_limit_code_reg;
      `TCG_IDX_COOL:   rdata_next = cool_limit_code_reg;
      `TCG_IDX_WARM:   rdata_next = warm_limit_code_reg;
      `TCG_IDX_HOT:    rdata_next = hot_limit_code_reg;
      `TCG_IDX_OPEN:   rdata_next = open_limit_code_reg;
      `TCG_IDX_ADJUST: rdata_next = temp_charge_adjust_reg;
      `TCG_IDX_CONFIG: rdata_next = config_reg;
      `TCG_IDX_FAULT:  rdata_next = {3'h0, fault_reg};
      `TCG_IDX_SENSE:  rdata_next = sense_hold_reg;
      `TCG_IDX_AUX:    rdata_next = aux_hold_reg;
      default:         rdata_next = `TCG_UNMAPPED;
    endcase
  end

  // Fault latch: a new event in the cycle of a read is kept, set wins over clear.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      fault_reg     <= 5'h00;
      reg_rdata_out <= 8'h00;
    end else begin
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_next;
      end
      if (reg_rd_in && reg_addr_in == `TCG_IDX_FAULT)
        fault_reg <= fault_set;
      else
        fault_reg <= fault_reg | fault_set;
    end
  end

  // Sample holding and region state.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      region_reg     <= RG_NORMAL;
      sense_hold_reg <= 8'h00;
      aux_hold_reg   <= 8'h00;
    end else begin
      region_reg <= region_next;
      if (timer_done && (supply_s2_reg || batt_s2_reg))
        sense_hold_reg <= sample_code;
      if (timer_done && config_reg[`TCG_CFG_AUX_NTC])
        aux_hold_reg <= aux_s2_reg[ADC_W-1 -: 8];
    end
  end

  // Bias pins follow the window timer; aux follows only in thermistor mode.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sense_bias_out <= 1'b0;
      aux_bias_out   <= 1'b0;
    end else begin
      sense_bias_out <= timer_bias;
      aux_bias_out   <= timer_bias && config_reg[`TCG_CFG_AUX_NTC];
    end
  end

  // Charge actions from the held region.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      charge_enable_out     <= 1'b0;
      safety_timer_hold_out <= 1'b0;
      charge_current_out    <= {FAST_CHARGE_CURRENT_SETTING_W{1'b0}};
      vreg_reduce_out       <= 1'b0;
      vreg_code_out         <= 4'h0;
    end else begin
      charge_enable_out     <= !(region_reg[`TCG_RG_HOT] || region_reg[`TCG_RG_COLD] ||
                                 region_reg[`TCG_RG_OPEN]);
      safety_timer_hold_out <= region_reg[`TCG_RG_HOT] || region_reg[`TCG_RG_COLD] ||
                               region_reg[`TCG_RG_OPEN];
      // Dropping the three low bits truncates to a whole current step.
      if (region_reg[`TCG_RG_COOL])
        charge_current_out <= scaled_current[FAST_CHARGE_CURRENT_SETTING_W+2:3];
      else
        charge_current_out <= fast_charge_current_setting_in;
      vreg_reduce_out <= region_reg[`TCG_RG_WARM];
      vreg_code_out   <= temp_charge_adjust_reg[`TCG_ADJ_VREG_LSB +: 4];
    end
  end

  // One fixed-length pulse per fault event; a new event restarts the pulse.
  // Thirteen bits hold the full pulse count at this clock; twelve would wrap it short.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pulse_cnt_reg <= 13'h0000;
      int_pulse_out <= 1'b0;
    end else begin
      if (|fault_set)
        pulse_cnt_reg <= PULSE_CYC[12:0];
      else if (pulse_cnt_reg != 13'h0000)
        pulse_cnt_reg <= pulse_cnt_reg - 13'h0001;
      int_pulse_out <= (|fault_set) || (pulse_cnt_reg > 13'h0001);
    end
  end

endmodule

/* File: verif/tcg_therm_model.sv */
// Thermistor divider and converter in front of the guard.
// Assumes the bench picks the temperature code; an unbiased pin gives no valid reading.
module tcg_therm_model (
  input  wire logic        sys_clk_in,
  input  wire logic        sense_bias_in,
  input  wire logic        aux_bias_in,
  input  wire logic [7:0]  temp_code_in,
  output logic      [15:0] sense_code_out,
  output logic      [15:0] aux_code_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] noise_reg = 16'hA5C3;

  // An unbiased pin floats, so a pattern that moves every cycle stands in for it.
  always @(posedge sys_clk_in) begin
    noise_reg <= {noise_reg[14:0], noise_reg[15] ^ noise_reg[13]};
  end

  // Full scale is 1.2 V; the top byte is the level the bench asks for.
  assign sense_code_out = sense_bias_in ? {temp_code_in, 8'h5A} : noise_reg;
  assign aux_code_out   = aux_bias_in ? {temp_code_in, 8'h3C} : ~noise_reg;
endmodule

/* File: verif/tcg_guard_monitor.sv */
// Checker bound to the thermistor charge guard.
// Assumes one clock and a synchronous active-high reset on the guard.
module tcg_guard_monitor #(
  parameter integer WIN_CYC    = 20,
  parameter integer PERIOD_CYC = 100
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic sense_bias_out,
  input wire logic aux_bias_out,
  input wire logic charge_enable_out,
  input wire logic safety_timer_hold_out,
  input wire logic vreg_reduce_out,
  input wire logic int_pulse_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer PULSE_CYC = 6400;
  logic [15:0] hi_reg;
  logic [15:0] lo_reg;
  logic [15:0] int_reg;
  logic [2:0]  rel_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  // Run lengths of bias and interrupt; the gap starts large so the first window passes.
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      hi_reg <= 16'h0000;
      lo_reg <= 16'h8000;
      int_reg <= 16'h0000;
      rel_reg <= 3'h0;
    end else begin
      hi_reg <= sense_bias_out ? hi_reg + 16'h0001 : 16'h0000;
      lo_reg <= sense_bias_out ? 16'h0000 : lo_reg + 16'h0001;
      int_reg <= int_pulse_out ? int_reg + 16'h0001 : 16'h0000;
      rel_reg <= (rel_reg == 3'h7) ? rel_reg : rel_reg + 3'h1;
    end
  end

  sequence s_recent_bias;
    $past(sense_bias_out) || $past(sense_bias_out, 2) || $past(sense_bias_out, 3) || $past(sense_bias_out, 4);
  endsequence

  // Outputs settle a few edges after reset, so early changes are not judged.
  sequence s_action_change;
    rel_reg == 3'h7 && ($changed(charge_enable_out) || $changed(vreg_reduce_out));
  endsequence

  a_bias_window: assert property ($fell(sense_bias_out) |-> hi_reg == WIN_CYC)
    else $error("bias window length wrong");
  a_bias_gap: assert property ($rose(sense_bias_out) |-> lo_reg >= PERIOD_CYC - WIN_CYC)
    else $error("bias gap too short");
  a_int_width: assert property ($fell(int_pulse_out) |-> int_reg == PULSE_CYC)
    else $error("interrupt pulse width wrong");
  a_int_on_sample: assert property ($rose(int_pulse_out) |-> s_recent_bias)
    else $error("interrupt outside a sample");
  a_action_hold: assert property (s_action_change |-> s_recent_bias)
    else $error("charge action changed between samples");
  a_suspend_pair: assert property (rel_reg == 3'h7 |-> charge_enable_out == !safety_timer_hold_out)
    else $error("charge and timer hold disagree");
  a_warm_charging: assert property (vreg_reduce_out |-> charge_enable_out)
    else $error("warm region stopped charging");
  a_aux_follows: assert property (aux_bias_out |-> sense_bias_out)
    else $error("aux bias outside sense window");
endmodule

bind tcg_guard tcg_guard_monitor #(.WIN_CYC(WIN_CYC), .PERIOD_CYC(PERIOD_CYC)) i_tcg_guard_monitor (
  .sys_clk_in, .sys_rst_in, .sense_bias_out, .aux_bias_out, .charge_enable_out, .safety_timer_hold_out,
  .vreg_reduce_out, .int_pulse_out);

/* File: verif/tb_tcg_guard.sv */
// Self-checking bench for the thermistor charge guard.
// Assumes a shortened sampling period and the converter model in front of the guard.
module tb_tcg_guard;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer PER = 100;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        supply_valid_in = 1'b1;
  logic        battery_present_in = 1'b1;
  logic [8:0]  fast_charge_current_setting_in = 9'h00C;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [7:0]  reg_wdata_in = 8'h00;
  logic [7:0]  temp = 8'h50;
  wire  [15:0] sense_code_in;
  wire  [15:0] aux_code_in;
  wire  [7:0]  reg_rdata_out;
  wire  [8:0]  charge_current_out;
  wire  [3:0]  vreg_code_out;
  wire         sense_bias_out;
  wire         aux_bias_out;
  wire         charge_enable_out;
  wire         safety_timer_hold_out;
  wire         vreg_reduce_out;
  wire         int_pulse_out;
  logic [7:0]  exp_q[$];
  logic        rd_q = 1'b0;
  int          error_cnt = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [31:0] rng = 32'h0000_0016;
  logic [7:0]  rst_a[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09};
  logic [7:0]  rst_v[7] = '{8'h7C, 8'h6D, 8'h38, 8'h27, 8'h00, 8'h00, 8'hC0};
  logic [7:0]  f_code[5] = '{8'h70, 8'h90, 8'h30, 8'h20, 8'hD0};
  logic [7:0]  f_bit[5] = '{8'h04, 8'h08, 8'h02, 8'h01, 8'h10};
  logic [4:0]  f_en = 5'h05;
  logic [4:0]  f_vr = 5'h04;

  tcg_guard #(.WIN_CYC(20), .PERIOD_CYC(PER)) i_tcg_guard (.sys_clk_in, .sys_rst_in, .supply_valid_in,
    .battery_present_in, .sense_code_in, .aux_code_in, .fast_charge_current_setting_in, .reg_wr_in, .reg_rd_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .sense_bias_out, .aux_bias_out, .charge_enable_out,
    .safety_timer_hold_out, .charge_current_out, .vreg_reduce_out, .vreg_code_out, .int_pulse_out);
  tcg_therm_model i_tcg_therm_model (.sys_clk_in, .sense_bias_in(sense_bias_out), .aux_bias_in(aux_bias_out),
    .temp_code_in(temp), .sense_code_out(sense_code_in), .aux_code_out(aux_code_in));

  // Free-running 50 MHz clock.
  always #10 sys_clk_in = ~sys_clk_in;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up;
    $display("errors %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Each access holds its strobe for exactly one sampling edge, then one idle edge.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    #2;
    reg_wr_in = w;
    reg_rd_in = !w;
    reg_addr_in = a;
    reg_wdata_in = d;
    if (!w) exp_q.push_back(d);
    @(posedge sys_clk_in);
    #2;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
  endtask

  task automatic wait_on(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while (((sel == 0) ? int_pulse_out : sense_bias_out) !== v && n < lim) begin
      @(posedge sys_clk_in);
      #2;
      n++;
    end
  endtask

  task automatic settle(input logic [7:0] code);
    temp = code;
    repeat (3 * PER) @(posedge sys_clk_in);
    #2;
  endtask

  task automatic on_fault(input logic [7:0] code, input logic [7:0] bits);
    temp = code;
    wait_on(0, 1'b1, 4 * PER);
    check(16'(int_pulse_out), 16'h0001);
    wait_on(0, 1'b0, 7000);
    check(16'(int_pulse_out), 16'h0000);
    acc(1'b0, 8'h06, bits);
    acc(1'b0, 8'h06, 8'h00);
  endtask

  task automatic count(input int cyc, output int hs, output int ha);
    hs = 0;
    ha = 0;
    repeat (cyc) begin
      @(posedge sys_clk_in);
      #1;
      hs += int'(sense_bias_out === 1'b1);
      ha += int'(aux_bias_out === 1'b1);
    end
    #1;
  endtask

  // Read data lands one edge after the strobe; the oldest note is compared then.
  always @(posedge sys_clk_in) begin
    if (rd_q) check(16'(reg_rdata_out), 16'(exp_q.pop_front()));
    rd_q <= reg_rd_in;
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up;
    end
  end

  // Main sequence: defaults, register port, every region, profiles, then bias gating.
  initial begin
    int i;
    int f;
    int hs;
    int ha;
    logic [8:0] cool;
    repeat (20) @(posedge sys_clk_in);
    #2;
    sys_rst_in = 1'b0;
    for (i = 0; i < 7; i++) acc(1'b0, rst_a[i], rst_v[i]);
    acc(1'b1, 8'h06, 8'h1F);
    acc(1'b0, 8'h06, 8'h00);
    acc(1'b1, 8'h0A, 8'h55);
    acc(1'b0, 8'h0A, 8'hFF);
    // Profile off, so random limits cannot turn the idle reading into a stray fault.
    acc(1'b1, 8'h05, 8'h02);
    for (i = 0; i < 4; i++) begin
      rng = xs(rng);
      acc(1'b1, 8'(i), rng[7:0]);
      acc(1'b0, 8'(i), rng[7:0]);
      acc(1'b1, 8'(i), rst_v[i]);
    end
    acc(1'b1, 8'h05, 8'h00);
    rng = xs(rng);
    f = int'(rng[2:0]);
    fast_charge_current_setting_in = rng[16:8];
    cool = 9'((int'(rng[16:8]) * (8 - f)) / 8);
    acc(1'b1, 8'h04, {rng[7:4], 1'b0, rng[2:0]});
    for (i = 0; i < 5; i++) begin
      on_fault(f_code[i], f_bit[i]);
      check(16'(charge_enable_out), 16'(f_en[i]));
      check(16'(safety_timer_hold_out), 16'(!f_en[i]));
      check(16'(charge_current_out), 16'((i == 0) ? cool : rng[16:8]));
      check(16'(vreg_reduce_out), 16'(f_vr[i]));
      check(16'(vreg_code_out), 16'(rng[7:4]));
      settle(8'h50);
      check(16'(charge_enable_out), 16'h0001);
    end
    acc(1'b1, 8'h05, 8'h01);
    settle(8'h70);
    check(16'(charge_current_out), 16'(rng[16:8]));
    on_fault(8'h90, 8'h08);
    settle(8'h50);
    acc(1'b1, 8'h05, 8'h02);
    settle(8'h20);
    check(16'(charge_enable_out), 16'h0001);
    on_fault(8'hD0, 8'h10);
    check(16'(charge_enable_out), 16'h0000);
    settle(8'h50);
    acc(1'b1, 8'h05, 8'h04);
    count(2 * PER, hs, ha);
    check(16'(hs > 0), 16'h0001);
    wait_on(1, 1'b1, 2 * PER);
    wait_on(1, 1'b0, PER);
    supply_valid_in = 1'b0;
    count(PER, hs, ha);
    count(2 * PER, hs, ha);
    check(16'(hs), 16'h0000);
    acc(1'b1, 8'h05, 8'h08);
    count(2 * PER, hs, ha);
    check(16'(ha == hs && ha > 0), 16'h0001);
    acc(1'b0, 8'h07, 8'h50);
    acc(1'b0, 8'h08, 8'h50);
    repeat (2) @(posedge sys_clk_in);
    wrap_up;
  end
endmodule
